//--- hw/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
    // register map over the plain port
    localparam logic [2:0] ADDR_CONTROL_0 = 3'h0;
    localparam logic [2:0] ADDR_CONTROL_2 = 3'h1;
    localparam logic [2:0] ADDR_RESULT_HIGH = 3'h2;
    localparam logic [2:0] ADDR_RESULT_LOW = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
    // control 0 fields
    localparam int CONVERTER_ON_BIT = 0;
    localparam int START_BUSY_BIT = 1;
    localparam int CHANNEL_LSB = 2;
    // control 2 fields
    localparam int CLOCK_SEL_LSB = 0;
    localparam int ACQ_SEL_LSB = 3;
    localparam int JUSTIFY_BIT = 7;
    localparam logic [7:0] CONTROL_0_RESET = 8'h00;
    localparam logic [7:0] CONTROL_2_RESET = 8'h00;
    localparam logic [7:0] CONTROL_0_WMASK = 8'h3D;
    localparam logic [7:0] CONTROL_2_WMASK = 8'hBF;
    localparam logic [3:0] LAST_CHANNEL = 4'hC;
    localparam int RESULT_BITS = 12;
    localparam logic [4:0] CONVERT_PERIODS = 5'h0D;
    // one instruction cycle = 4 oscillator periods
    localparam int TCY_NS = 40;
    localparam int CLK_NS = 10;
    localparam int RC_DELAY_CYCLES = (TCY_NS + CLK_NS - 1) / CLK_NS;
    localparam int RC_PERIOD_NS = 2500;
    localparam int RC_HALF_CYCLES = RC_PERIOD_NS / CLK_NS / 2;
    localparam int IRQ_DONE_BIT = 0;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_SAMPLE = 5'h02,
        ST_RC_WAIT = 5'h04,
        ST_ACQUIRE = 5'h08,
        ST_CONVERT = 5'h10
    } adc_state_t;

    typedef struct packed {
        logic [3:0] channel;
        logic sample;
        logic convert_step;
    } analog_ctl_t;
endpackage
`default_nettype wire

//--- hw/adc_tad_clock.sv
`default_nettype none
// produces one-cycle ticks, one per conversion bit period
module adc_tad_clock
    import adc_ctrl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [2:0] select_i,
    output logic tick_o
);
    logic [7:0] count;
    logic [7:0] limit;

    function automatic logic [7:0] half_period(input logic [2:0] sel);
        unique case (sel)
            3'h0: half_period = 8'h01;
            3'h4: half_period = 8'h02;
            3'h1: half_period = 8'h04;
            3'h5: half_period = 8'h08;
            3'h2: half_period = 8'h10;
            3'h6: half_period = 8'h20;
            default: half_period = 8'(RC_HALF_CYCLES); // rc source
        endcase
    endfunction

    // full period in system clocks is twice the half period
    assign limit = 8'(half_period(select_i) * 2 - 1);

    always_ff @(posedge mclk_i) begin
        if (rst_i || !run_i) begin
            count <= 8'h00;
        end else if (count >= limit) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end

    assign tick_o = run_i && (count >= limit);
endmodule
`default_nettype wire

//--- hw/adc_12bit_control.sv
`default_nettype none
// How it works
// - each conversion yields a twelve-bit result from the selected input
// - ten inputs on small package, thirteen on large ones
// - four-bit channel field at control 0 bits 5..2, codes 0..12 valid
// - unimplemented channel codes still convert, giving a floating reading
// - start/busy bit reads one while converting, zero when idle
// - enable bit 0 powers the converter on, clearing it disables
// - unimplemented bits read zero: control 0 bits 7..6, control 2 bit 6
// - justify bit 7 set gives right justification, clear gives left
// - acquisition field bits 5..3 picks 0..20 bit periods
// - clock field bits 2..0 picks system divider or rc oscillator
// - rc clock source waits one instruction cycle before clocking
// - hold capacitor disconnects from the pin when conversion starts
// - nonzero acquisition code samples that long, then converts
// - zero acquisition code converts at once; zero is reset value
// - each conversion lasts thirteen bit periods
// - on completion clear busy, set done flag, resume sampling
module adc_12bit_control
    import adc_ctrl_pkg::*;
#(
    parameter int NUM_INPUTS = 13
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output analog_ctl_t analog_o,
    output logic input_valid_o,
    input wire logic comparator_i
);
    logic [7:0] control_0;
    logic [7:0] control_2;
    logic [7:0] result_high;
    logic [7:0] result_low;
    logic irq_status;
    logic irq_mask;
    adc_state_t state;
    logic [4:0] periods;
    logic [2:0] rc_wait;
    logic [RESULT_BITS-1:0] shift;
    logic tad_tick;
    logic tad_run;
    logic start_write;
    logic done;
    logic converter_on;
    logic [3:0] channel;
    logic [4:0] acq_periods;

    function automatic logic [4:0] acq_len(input logic [2:0] code);
        unique case (code)
            3'h0: acq_len = 5'h00;
            3'h1: acq_len = 5'h02;
            3'h2: acq_len = 5'h04;
            3'h3: acq_len = 5'h06;
            3'h4: acq_len = 5'h08;
            3'h5: acq_len = 5'h0C;
            3'h6: acq_len = 5'h10;
            3'h7: acq_len = 5'h14;
        endcase
    endfunction

    function automatic logic is_rc(input logic [2:0] sel);
        is_rc = sel[1] && sel[0];
    endfunction

    assign converter_on = control_0[CONVERTER_ON_BIT];
    assign channel = control_0[CHANNEL_LSB +: 4];
    assign acq_periods = acq_len(control_2[ACQ_SEL_LSB +: 3]);
    assign start_write = wr_i && addr_i == ADDR_CONTROL_0
        && wdata_i[START_BUSY_BIT] && wdata_i[CONVERTER_ON_BIT];
    assign done = state == ST_CONVERT && tad_tick && periods == CONVERT_PERIODS - 5'h01;
    assign tad_run = state == ST_ACQUIRE || state == ST_CONVERT;

    adc_tad_clock u_tad (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .run_i(tad_run),
        .select_i(control_2[CLOCK_SEL_LSB +: 3]),
        .tick_o(tad_tick)
    );

    // sequencer
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= ST_OFF;
            periods <= 5'h00;
            rc_wait <= 3'h0;
        end else if (!converter_on) begin
            state <= ST_OFF;
            periods <= 5'h00;
        end else begin
            unique case (state)
                ST_OFF: state <= ST_SAMPLE;
                ST_SAMPLE: begin
                    if (start_write) begin
                        periods <= 5'h00;
                        rc_wait <= 3'(RC_DELAY_CYCLES - 1);
                        if (is_rc(control_2[CLOCK_SEL_LSB +: 3])) begin
                            state <= ST_RC_WAIT;
                        end else if (acq_periods != 5'h00) begin
                            state <= ST_ACQUIRE;
                        end else begin
                            state <= ST_CONVERT;
                        end
                    end
                end
                ST_RC_WAIT: begin
                    rc_wait <= rc_wait - 3'h1;
                    if (rc_wait == 3'h0) begin
                        state <= (acq_periods != 5'h00) ? ST_ACQUIRE : ST_CONVERT;
                    end
                end
                ST_ACQUIRE: begin
                    if (tad_tick) begin
                        if (periods == acq_periods - 5'h01) begin
                            periods <= 5'h00;
                            state <= ST_CONVERT;
                        end else begin
                            periods <= periods + 5'h01;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (tad_tick) begin
                        periods <= periods + 5'h01;
                        if (done) begin
                            periods <= 5'h00;
                            state <= ST_SAMPLE;
                        end
                    end
                end
                default: state <= ST_OFF;
            endcase
        end
    end

    // successive approximation: one comparator decision per bit period after the first
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            shift <= '0;
        end else if (state == ST_CONVERT && tad_tick && periods != 5'h00) begin
            shift <= {shift[RESULT_BITS-2:0], comparator_i};
        end
    end

    // results land together only at the end of a conversion
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            result_high <= 8'h00;
            result_low <= 8'h00;
        end else if (done) begin
            if (control_2[JUSTIFY_BIT]) begin
                result_high <= {4'h0, shift[RESULT_BITS-2:7]};
                result_low <= {shift[6:0], comparator_i};
            end else begin
                result_high <= {shift[10:3]};
                result_low <= {shift[2:0], comparator_i, 4'h0};
            end
        end
    end

    // control registers; hardware clears start/busy at completion
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            control_0 <= CONTROL_0_RESET;
        end else begin
            if (wr_i && addr_i == ADDR_CONTROL_0) begin
                control_0 <= wdata_i & CONTROL_0_WMASK;
                // start only taken while sampling; mid-run writes keep busy only if they keep enable bit 0 set
                if (state == ST_SAMPLE && converter_on) begin
                    control_0[START_BUSY_BIT] <= start_write;
                end else begin
                    control_0[START_BUSY_BIT] <= control_0[START_BUSY_BIT]
                        && wdata_i[CONVERTER_ON_BIT] && !done;
                end
            end else if (done || !converter_on) begin
                control_0[START_BUSY_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            control_2 <= CONTROL_2_RESET;
        end else if (wr_i && addr_i == ADDR_CONTROL_2) begin
            control_2 <= wdata_i & CONTROL_2_WMASK;
        end
    end

    // sticky done flag; a set in the clearing read cycle wins
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_status <= 1'b0;
            irq_mask <= 1'b0;
        end else begin
            if (done) begin
                irq_status <= 1'b1;
            end else if (rd_i && addr_i == ADDR_IRQ_STATUS) begin
                irq_status <= 1'b0;
            end
            if (wr_i && addr_i == ADDR_IRQ_MASK) begin
                irq_mask <= wdata_i[IRQ_DONE_BIT];
            end
        end
    end

    assign irq_o = irq_status && irq_mask;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                ADDR_CONTROL_0: rdata_o <= control_0;
                ADDR_CONTROL_2: rdata_o <= control_2;
                ADDR_RESULT_HIGH: rdata_o <= result_high;
                ADDR_RESULT_LOW: rdata_o <= result_low;
                ADDR_IRQ_STATUS: rdata_o <= {7'h00, irq_status};
                ADDR_IRQ_MASK: rdata_o <= {7'h00, irq_mask};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // analog side: sample switch open from conversion start to its end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            analog_o <= '0;
            input_valid_o <= 1'b0;
        end else begin
            analog_o.channel <= channel;
            analog_o.sample <= converter_on && state != ST_CONVERT
                && !(state == ST_SAMPLE && start_write && acq_periods == 5'h00
                && !is_rc(control_2[CLOCK_SEL_LSB +: 3]));
            analog_o.convert_step <= state == ST_CONVERT && tad_tick;
            // unimplemented codes still run, reading a floating node
            // small package lacks inputs 5 to 7 but keeps 8 to 12
            input_valid_o <= (channel <= LAST_CHANNEL)
                && (NUM_INPUTS > 32'(LAST_CHANNEL) || channel < 4'h5 || channel > 4'h7);
        end
    end

    // tick count kept apart from the sequencer, for the length check
    logic [3:0] conv_ticks;
    always_ff @(posedge mclk_i) begin
        if (rst_i || state != ST_CONVERT) begin
            conv_ticks <= 4'h0;
        end else if (tad_tick) begin
            conv_ticks <= conv_ticks + 4'h1;
        end
    end

    busy_tracks_state_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ST_CONVERT |-> control_0[START_BUSY_BIT])
        else $error("busy low during conversion");
    done_clears_busy_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        done && !wr_i |=> !control_0[START_BUSY_BIT] && irq_status)
        else $error("completion did not clear busy or set flag");
    reserved_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        control_0[7:6] == 2'b00 && control_2[6] == 1'b0)
        else $error("reserved bit set");
    hold_open_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ST_CONVERT |=> !analog_o.sample)
        else $error("sample switch closed in conversion");
    off_idles_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !converter_on |=> state == ST_OFF)
        else $error("converter ran while off");
    zero_acq_direct_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ST_SAMPLE && start_write && acq_periods == 5'h00
        && converter_on && !is_rc(control_2[2:0]) |=> state == ST_CONVERT)
        else $error("zero acquisition did not convert at once");
    rc_delay_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ST_SAMPLE && start_write && is_rc(control_2[2:0])
        && converter_on |=> state == ST_RC_WAIT [*4])
        else $error("rc start delay wrong");
    thirteen_periods_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        done |-> conv_ticks == 4'hC)
        else $error("conversion length wrong");
    justify_fill_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        done && control_2[JUSTIFY_BIT] && !(wr_i && addr_i == ADDR_CONTROL_2)
        |=> result_high[7:4] == 4'h0)
        else $error("right justified fill not zero");
    acq_then_convert_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ST_ACQUIRE ##1 state == ST_CONVERT |-> $past(tad_tick))
        else $error("acquisition ended off a bit period");
    set_wins_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        done |=> irq_status)
        else $error("done flag lost against a clearing read");
    results_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !done |=> $stable(result_high) && $stable(result_low))
        else $error("result changed outside completion");
    cover_done_c: cover property (@(posedge mclk_i) disable iff (rst_i) done);
    cover_acq_c: cover property (@(posedge mclk_i) disable iff (rst_i) state == ST_ACQUIRE);
    cover_rc_c: cover property (@(posedge mclk_i) disable iff (rst_i) state == ST_RC_WAIT);
    cover_right_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        done && control_2[JUSTIFY_BIT]);
    cover_float_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        done && !input_valid_o);
endmodule
`default_nettype wire

//--- verification/adc_analog_model.sv
`default_nettype none
// analog inputs plus hold capacitor; each implemented channel holds a fixed level, others sample noise
module adc_analog_model
    import adc_ctrl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire analog_ctl_t analog_i,
    input wire logic valid_i,
    output logic comparator_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] hold;
    logic [11:0] noise;
    logic [3:0] cnt;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hold <= 12'h000;
            noise <= 12'h5A3;
            cnt <= 4'h0;
        end else begin
            noise <= {noise[10:0], noise[11] ^ noise[5]};
            if (analog_i.sample) begin
                hold <= valid_i ? {analog_i.channel, 8'hC3} : noise;
                cnt <= 4'h0;
            end else if (analog_i.convert_step && cnt != 4'hF) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
    // first period is sample-to-hold, then msb first
    assign comparator_o = (cnt >= 4'h1 && cnt <= 4'hC) ? hold[4'hC - cnt] : ~hold[0];
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`default_nettype none
module tb_top;
    import adc_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i;
    logic rst_i;
    logic [2:0] addr_i;
    logic [7:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] rdata_o;
    logic irq_o;
    analog_ctl_t analog_o;
    logic input_valid_o;
    logic comparator_i;
    int fail_count;
    int cmp_count;

    adc_12bit_control adc_12bit_control_inst (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .analog_o(analog_o), .input_valid_o(input_valid_o), .comparator_i(comparator_i));
    adc_analog_model adc_analog_model_inst (.mclk_i(mclk_i), .rst_i(rst_i), .analog_i(analog_o),
        .valid_i(input_valid_o), .comparator_o(comparator_i));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic final_report();
        $display("checks=%0d errors=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    function automatic int period_of(input logic [2:0] c);
        case (c)
            3'h0: return 2;
            3'h1: return 8;
            3'h2: return 32;
            3'h4: return 4;
            3'h5: return 16;
            3'h6: return 64;
            default: return 2 * RC_HALF_CYCLES;
        endcase
    endfunction

    function automatic int acq_of(input logic [2:0] a);
        case (a)
            3'h0: return 0;
            3'h1: return 2;
            3'h2: return 4;
            3'h3: return 6;
            3'h4: return 8;
            3'h5: return 12;
            3'h6: return 16;
            default: return 20;
        endcase
    endfunction

    task automatic wait_sample(input logic lvl, inout int n);
        while (analog_o.sample !== lvl && n < 20000) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
    endtask

    task automatic test_reset();
        logic [7:0] d;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], d);
            chk({8'h00, d}, 16'h0000);
        end
        chk({15'h0000, irq_o}, 16'h0000);
    endtask

    task automatic test_masks();
        logic [7:0] d;
        wr(ADDR_CONTROL_0, 8'hFD);
        rd(ADDR_CONTROL_0, d);
        chk({8'h00, d}, 16'h003D);
        wr(ADDR_CONTROL_2, 8'hFF);
        rd(ADDR_CONTROL_2, d);
        chk({8'h00, d}, 16'h00BF);
        wr(ADDR_CONTROL_0, 8'h00);
        wr(ADDR_CONTROL_2, 8'h00);
    endtask

    task automatic test_disabled();
        logic [7:0] d;
        wr(ADDR_CONTROL_0, 8'h02);
        repeat (40) @(posedge mclk_i);
        rd(ADDR_CONTROL_0, d);
        chk({8'h00, d}, 16'h0000);
        rd(ADDR_IRQ_STATUS, d);
        chk({8'h00, d}, 16'h0000);
    endtask

    task automatic test_conv(input logic [3:0] ch, input logic [2:0] acq, input logic [2:0] ck,
                             input logic just);
        logic [7:0] d;
        logic [11:0] v;
        int per;
        int rc;
        int t1;
        int t2;
        per = period_of(ck);
        rc = (ck[1:0] == 2'b11) ? RC_DELAY_CYCLES : 0;
        t1 = 0;
        t2 = 2;
        v = {ch, 8'hC3};
        wr(ADDR_CONTROL_0, {2'b00, ch, 2'b01});
        wr(ADDR_CONTROL_2, {just, 1'b0, acq, ck});
        // fixed 30-cycle settle before start, ahead of any programmed acquisition time
        repeat (30) @(posedge mclk_i);
        #1;
        chk({15'h0000, input_valid_o}, {15'h0000, ch <= LAST_CHANNEL});
        wr(ADDR_CONTROL_0, {2'b00, ch, 2'b11});
        wait_sample(1'b0, t1);
        chk_rng(t1, (acq_of(acq) == 0) ? 0 : (acq_of(acq) - 1) * per, (acq_of(acq) + 1) * per + rc + 4);
        rd(ADDR_CONTROL_0, d);
        chk({8'h00, d}, {8'h00, 2'b00, ch, 2'b11});
        wait_sample(1'b1, t2);
        chk_rng(t2, 12 * per, 14 * per + 4);
        rd(ADDR_CONTROL_0, d);
        chk({8'h00, d}, {8'h00, 2'b00, ch, 2'b01});
        chk({15'h0000, irq_o}, 16'h0001);
        wr(ADDR_IRQ_MASK, 8'h00);
        #1;
        chk({15'h0000, irq_o}, 16'h0000);
        wr(ADDR_IRQ_MASK, 8'h01);
        if (ch <= LAST_CHANNEL) begin
            rd(ADDR_RESULT_HIGH, d);
            chk({8'h00, d}, {8'h00, just ? {4'h0, v[11:8]} : v[11:4]});
            rd(ADDR_RESULT_LOW, d);
            chk({8'h00, d}, {8'h00, just ? v[7:0] : {v[3:0], 4'h0}});
        end
        rd(ADDR_IRQ_STATUS, d);
        chk({8'h00, d}, 16'h0001);
        rd(ADDR_IRQ_STATUS, d);
        chk({8'h00, d}, 16'h0000);
        chk({15'h0000, irq_o}, 16'h0000);
    endtask

    initial begin
        fail_count = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        addr_i = 3'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        test_reset();
        test_masks();
        test_disabled();
        wr(ADDR_IRQ_MASK, 8'h01);
        for (int i = 0; i < 8; i++) begin
            test_conv(i[3:0] + 4'h5, i[2:0], i[2:0], i[0]);
        end
        test_conv(4'hD, 3'h0, 3'h0, 1'b1);
        test_conv(4'h0, 3'h1, 3'h4, 1'b0);
        final_report();
    end

    // whole run is near 17k cycles
    initial begin
        #300000;
        fail_count++;
        final_report();
    end
endmodule
`default_nettype wire
